// ==== gimc_top.sv ====
`timescale 1ns/10ps
// Contract
// - code -4 blocks a direction when low; reference state picks which.
// - remote offset and web speed accepted only on the dedicated input.
// - latch-error input high captures the present web deviation.
// - latch-error falling adds captured correction to the set position; code applies it in the integral type only.
// - series break contacts use code -3 reference and -4 end position.
// - code -6 stops negative, code -5 stops positive motion when low.
// - proportional type outputs a motion speed from position error.
// - integral type outputs a target actuator position.
// - master-slave type makes the slave follow the master exactly.
// - three-level type drives a three-state actuator.
// - sensor addressing runs once after reset on both connectors, again on a swap in setting two.
// - setting zero only reports found addresses, assigns none.
// - fixed setting gives device one right, device two left.
// - fixed setting uses the card's own group for sensors.
// - setting two assigns each connector's parameter address, also on swap.
// - report each connector's sensor address.
module gimc_top #(
  parameter int NUM_IN = 5,
  parameter int POS_W  = 16
) (
  input  wire logic                      i_clk,          // 40 mhz
  input  wire logic                      i_rst,          // sync, high
  input  wire logic [NUM_IN-1:0]         i_din,          // digital inputs
  input  wire logic [NUM_IN*6-1:0]       i_code,         // 6b code each
  input  wire logic [1:0]                i_guider_type,  // guider type
  input  wire logic                      i_operate,      // operate setting
  input  wire logic [1:0]                i_auto_addr,    // addressing mode
  input  wire logic [3:0]                i_card_group,   // own group
  input  wire logic [7:0]                i_right_param,  // right addr param
  input  wire logic [7:0]                i_left_param,   // left addr param
  input  wire gimc_pkg::gimc_addr_type   i_right_found,  // right sensor
  input  wire gimc_pkg::gimc_addr_type   i_left_found,   // left sensor
  input  wire logic signed [POS_W-1:0]   i_web_dev,      // web deviation
  input  wire logic signed [POS_W-1:0]   i_act_pos,      // actuator pos
  input  wire logic signed [POS_W-1:0]   i_set_pos,      // set position
  input  wire logic signed [POS_W-1:0]   i_master_pos,   // master pos
  output logic                           o_block_pos,    // stop + motion
  output logic                           o_block_neg,    // stop - motion
  output logic                           o_osc_on,       // oscillation
  output logic                           o_offset_sel,   // remote offset
  output logic                           o_speed_sel,    // speed measure
  output gimc_pkg::gimc_keys_type        o_keys,         // operator keys
  output logic signed [POS_W-1:0]        o_target,       // position/speed
  output logic                           o_is_speed,     // target is speed
  output logic [1:0]                     o_three_lvl,    // b1 pos, b0 neg
  output logic                           o_hybrid,       // hybrid active
  output logic                           o_addr_wr,      // assign strobe
  output gimc_pkg::gimc_addr_type        o_right_addr,   // right report
  output gimc_pkg::gimc_addr_type        o_left_addr     // left report
);

  function automatic logic [5:0] code_of(input logic [NUM_IN*6-1:0] c,
                                         input int k);
    code_of = c[k*6 +: 6];
  endfunction

  // input stage
  logic                    blk_pos_d, blk_pos_q, blk_neg_d, blk_neg_q;
  logic                    osc_d, osc_q, offs_d, offs_q, spd_d, spd_q;
  gimc_pkg::gimc_keys_type keys_d, keys_q;
  logic                    latch_in, latch_prev_q, ref_q, ref_d;
  logic signed [POS_W-1:0] capt_d, capt_q, corr_d, corr_q;

  always_comb begin
    logic [5:0] c;
    c = 6'h00;
    blk_pos_d = 1'b0;
    blk_neg_d = 1'b0;
    osc_d = osc_q;
    offs_d = 1'b0;
    spd_d = 1'b0;
    keys_d = '0;
    latch_in = 1'b0;
    ref_d = ref_q;
    for (int k = 0; k < NUM_IN; k++) begin
      c = code_of(i_code, k);
      if (c == gimc_pkg::FN_REF_POS) begin
        ref_d = i_din[k];
      end
    end
    for (int k = 0; k < NUM_IN; k++) begin
      c = code_of(i_code, k);
      unique case (c)
        gimc_pkg::FN_UNLOCK_PM: begin
          // ref reached (open) means we sit at the positive end
          if (!i_din[k] && !ref_d) blk_pos_d = 1'b1;
          if (!i_din[k] && ref_d) blk_neg_d = 1'b1;
        end
        gimc_pkg::FN_LOCK_PM: begin
          if (i_din[k] && !ref_d) blk_pos_d = 1'b1;
          if (i_din[k] && ref_d) blk_neg_d = 1'b1;
        end
        gimc_pkg::FN_UNLOCK_POS: if (!i_din[k]) blk_pos_d = 1'b1;
        gimc_pkg::FN_UNLOCK_NEG: if (!i_din[k]) blk_neg_d = 1'b1;
        gimc_pkg::FN_LOCK_POS: if (i_din[k]) blk_pos_d = 1'b1;
        gimc_pkg::FN_LOCK_NEG: if (i_din[k]) blk_neg_d = 1'b1;
        gimc_pkg::FN_OSC_ON: if (i_din[k]) osc_d = 1'b1;
        gimc_pkg::FN_OSC_OFF: if (i_din[k]) osc_d = 1'b0;
        gimc_pkg::FN_OFFSET_REM:
          if (k == gimc_pkg::DEDIC_IN) offs_d = i_din[k];
        gimc_pkg::FN_SPEED_MEAS:
          if (k == gimc_pkg::DEDIC_IN) spd_d = i_din[k];
        gimc_pkg::FN_KEY_MANUAL: keys_d.manual = i_din[k];
        gimc_pkg::FN_KEY_RIGHT: keys_d.right = i_din[k];
        gimc_pkg::FN_KEY_LEFT: keys_d.left = i_din[k];
        gimc_pkg::FN_KEY_AUTO: keys_d.autom = i_din[k];
        gimc_pkg::FN_KEY_CENTER: keys_d.center = i_din[k];
        gimc_pkg::FN_LATCH_ERR: latch_in = i_din[k];
        default: ;
      endcase
    end
    capt_d = latch_in ? i_web_dev : capt_q;
    corr_d = corr_q;
    if (latch_prev_q && !latch_in) begin
      corr_d = POS_W'(corr_q + capt_q);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      blk_pos_q <= 1'b0;
      blk_neg_q <= 1'b0;
      osc_q <= 1'b0;
      offs_q <= 1'b0;
      spd_q <= 1'b0;
      keys_q <= '0;
      latch_prev_q <= 1'b0;
      ref_q <= 1'b0;
      capt_q <= '0;
      corr_q <= '0;
    end else begin
      blk_pos_q <= blk_pos_d;
      blk_neg_q <= blk_neg_d;
      osc_q <= osc_d;
      offs_q <= offs_d;
      spd_q <= spd_d;
      keys_q <= keys_d;
      latch_prev_q <= latch_in;
      ref_q <= ref_d;
      capt_q <= capt_d;
      corr_q <= corr_d;
    end
  end

  // guider output
  logic signed [POS_W-1:0] tgt_d, tgt_q;
  logic                    spd_flag_d, spd_flag_q;
  logic [1:0]              three_d, three_q;
  logic signed [POS_W-1:0] err;

  always_comb begin
    err = POS_W'(i_set_pos - i_act_pos);
    tgt_d = '0;
    spd_flag_d = 1'b0;
    three_d = 2'h0;
    unique case (i_guider_type)
      gimc_pkg::GT_PROP: begin
        tgt_d = err;
        spd_flag_d = 1'b1;
      end
      gimc_pkg::GT_INTEG: tgt_d = POS_W'(i_set_pos + corr_q);
      gimc_pkg::GT_SLAVE: tgt_d = i_master_pos;
      gimc_pkg::GT_THREE: begin
        three_d = (err > 0) ? 2'h2 : (err < 0) ? 2'h1 : 2'h0;
        tgt_d = i_set_pos;
      end
    endcase
    // gate with this cycle's locks, so a drive never outlives its lock
    if (three_d[1] && blk_pos_d) three_d[1] = 1'b0;
    if (three_d[0] && blk_neg_d) three_d[0] = 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tgt_q <= '0;
      spd_flag_q <= 1'b0;
      three_q <= 2'h0;
    end else begin
      tgt_q <= tgt_d;
      spd_flag_q <= spd_flag_d;
      three_q <= three_d;
    end
  end

  // sensor addressing after reset, again on a swap in parameter mode
  gimc_pkg::gimc_addr_state_type st_d, st_q;
  gimc_pkg::gimc_addr_type       ra_d, ra_q, la_d, la_q;
  logic                          wr_d, wr_q;

  always_comb begin
    st_d = st_q;
    ra_d = ra_q;
    la_d = la_q;
    wr_d = 1'b0;
    unique case (st_q)
      gimc_pkg::GIMC_ADDR_WAIT: st_d = gimc_pkg::GIMC_ADDR_RUN;
      gimc_pkg::GIMC_ADDR_RUN: begin
        st_d = gimc_pkg::GIMC_ADDR_DONE;
        ra_d = i_right_found;
        la_d = i_left_found;
        if (i_auto_addr == gimc_pkg::AA_FIXED) begin
          ra_d = '{valid: i_right_found.valid,
                   addr: {i_card_group, gimc_pkg::DEV_RIGHT}};
          la_d = '{valid: i_left_found.valid,
                   addr: {i_card_group, gimc_pkg::DEV_LEFT}};
          wr_d = 1'b1;
        end else if (i_auto_addr == gimc_pkg::AA_PARAM) begin
          ra_d = '{valid: i_right_found.valid, addr: i_right_param};
          la_d = '{valid: i_left_found.valid, addr: i_left_param};
          wr_d = 1'b1;
        end
      end
      gimc_pkg::GIMC_ADDR_DONE: begin
        // a swapped sensor in parameter mode gets its address again
        if (i_auto_addr == gimc_pkg::AA_PARAM &&
            ((i_right_found.valid && !ra_q.valid) ||
             (i_left_found.valid && !la_q.valid))) begin
          st_d = gimc_pkg::GIMC_ADDR_RUN;
        end else begin
          if (i_auto_addr == gimc_pkg::AA_PARAM) begin
            ra_d.valid = i_right_found.valid;
            la_d.valid = i_left_found.valid;
          end
        end
      end
      default: st_d = gimc_pkg::GIMC_ADDR_WAIT;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= gimc_pkg::GIMC_ADDR_WAIT;
      ra_q <= '0;
      la_q <= '0;
      wr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ra_q <= ra_d;
      la_q <= la_d;
      wr_q <= wr_d;
    end
  end

  logic hyb_d, hyb_q;
  always_comb hyb_d = i_operate;
  always_ff @(posedge i_clk) begin
    if (i_rst) hyb_q <= 1'b0;
    else hyb_q <= hyb_d;
  end

  assign o_block_pos  = blk_pos_q;
  assign o_block_neg  = blk_neg_q;
  assign o_osc_on     = osc_q;
  assign o_offset_sel = offs_q;
  assign o_speed_sel  = spd_q;
  assign o_keys       = keys_q;
  assign o_target     = tgt_q;
  assign o_is_speed   = spd_flag_q;
  assign o_three_lvl  = three_q;
  assign o_hybrid     = hyb_q;
  assign o_addr_wr    = wr_q;
  assign o_right_addr = ra_q;
  assign o_left_addr  = la_q;

  wr_once_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_addr_wr |=> !o_addr_wr) else $error("assign strobe too long");
  fixed_dev_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_addr_wr && i_auto_addr == gimc_pkg::AA_FIXED && $stable(i_auto_addr))
    |-> o_right_addr.addr[3:0] == gimc_pkg::DEV_RIGHT)
    else $error("right device number wrong");
  report_only_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ($past(i_auto_addr) == gimc_pkg::AA_REPORT) |-> !o_addr_wr)
    else $error("report mode assigned");
  dedic_in_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_rst && code_of(i_code, 0) == gimc_pkg::FN_OFFSET_REM &&
     code_of(i_code, gimc_pkg::DEDIC_IN) != gimc_pkg::FN_OFFSET_REM)
    |=> !o_offset_sel) else $error("offset on wrong input");
  neg_lock_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_rst && code_of(i_code, 0) == gimc_pkg::FN_UNLOCK_NEG && !i_din[0])
    |=> o_block_neg) else $error("negative lock missed");
  pos_lock_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_rst && code_of(i_code, 1) == gimc_pkg::FN_UNLOCK_POS && !i_din[1])
    |=> o_block_pos) else $error("positive lock missed");
  prop_speed_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_rst && i_guider_type == gimc_pkg::GT_PROP)
    |=> o_is_speed && o_target == $past(i_set_pos - i_act_pos))
    else $error("prop output wrong");
  slave_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_rst && i_guider_type == gimc_pkg::GT_SLAVE)
    |=> o_target == $past(i_master_pos))
    else $error("slave not following");
endmodule

// ==== gimc_pkg.sv ====
package gimc_pkg;
  localparam int CODE_W   = 6;
  localparam int NUM_IN   = 5;
  localparam int DEDIC_IN = 4;
  localparam int POS_W    = 16;
  localparam int ADDR_W   = 8;

  localparam logic [5:0] FN_NONE       = 6'h00;
  localparam logic [5:0] FN_REF_POS    = 6'h3d;
  localparam logic [5:0] FN_LOCK_PM    = 6'h04;
  localparam logic [5:0] FN_UNLOCK_PM  = 6'h3c;
  localparam logic [5:0] FN_LOCK_POS   = 6'h05;
  localparam logic [5:0] FN_UNLOCK_POS = 6'h3b;
  localparam logic [5:0] FN_LOCK_NEG   = 6'h06;
  localparam logic [5:0] FN_UNLOCK_NEG = 6'h3a;
  localparam logic [5:0] FN_OSC_ON     = 6'h08;
  localparam logic [5:0] FN_OSC_OFF    = 6'h38;
  localparam logic [5:0] FN_OFFSET_REM = 6'h09;
  localparam logic [5:0] FN_SPEED_MEAS = 6'h0a;
  localparam logic [5:0] FN_KEY_MANUAL = 6'h0b;
  localparam logic [5:0] FN_KEY_RIGHT  = 6'h0c;
  localparam logic [5:0] FN_KEY_LEFT   = 6'h0d;
  localparam logic [5:0] FN_KEY_AUTO   = 6'h0e;
  localparam logic [5:0] FN_KEY_CENTER = 6'h0f;
  localparam logic [5:0] FN_LATCH_ERR  = 6'h10;

  localparam logic [1:0] GT_PROP   = 2'h0;
  localparam logic [1:0] GT_INTEG  = 2'h1;
  localparam logic [1:0] GT_SLAVE  = 2'h2;
  localparam logic [1:0] GT_THREE  = 2'h3;

  localparam logic [1:0] AA_REPORT = 2'h0;
  localparam logic [1:0] AA_FIXED  = 2'h1;
  localparam logic [1:0] AA_PARAM  = 2'h2;

  localparam logic [3:0] DEV_RIGHT = 4'h1;
  localparam logic [3:0] DEV_LEFT  = 4'h2;

  typedef struct packed {
    logic manual;
    logic right;
    logic left;
    logic autom;
    logic center;
  } gimc_keys_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
  } gimc_addr_type;

  typedef enum logic [1:0] {
    GIMC_ADDR_WAIT,
    GIMC_ADDR_RUN,
    GIMC_ADDR_DONE
  } gimc_addr_state_type;
endpackage

// ==== gimc_sensor_model.sv ====
`timescale 1ns/10ps
// capable edge sensors plugged straight into the two connectors
module gimc_sensor_model #(
  parameter logic [7:0] RIGHT_ID = 8'h5a,  // arbitrary preset address
  parameter logic [7:0] LEFT_ID  = 8'h6b   // arbitrary preset address
) (
  input  wire logic               i_clk,    // system clock
  input  wire logic               i_r_on,   // right sensor fitted
  input  wire logic               i_l_on,   // left sensor fitted
  output gimc_pkg::gimc_addr_type o_right,  // right connector view
  output gimc_pkg::gimc_addr_type o_left    // left connector view
);
  // an unplugged connector floats, so its address bus keeps toggling
  always_ff @(posedge i_clk) begin
    o_right <= i_r_on ? {1'h1, RIGHT_ID} : {1'h0, ~o_right.addr};
    o_left  <= i_l_on ? {1'h1, LEFT_ID} : {1'h0, ~o_left.addr};
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  logic                    clk = 1'h0, rst = 1'h1, op = 1'h0;
  logic                    r_on = 1'h1, l_on = 1'h1, bpos, bneg, osc;
  logic                    offs, spd, isspd, hyb, awr;
  logic [4:0]              din = 5'h00;
  logic [29:0]             code = 30'h0;
  logic [1:0]              gtype = 2'h0, amode = 2'h0, three;
  logic [3:0]              grp = 4'h3;
  logic [7:0]              rpar = 8'h21, lpar = 8'h42;
  logic signed [15:0]      dev = 16'h0, act = 16'h0, setp = 16'h0;
  logic signed [15:0]      mpos = 16'h0, tgt;
  gimc_pkg::gimc_addr_type rfnd, lfnd, raddr, laddr;
  gimc_pkg::gimc_keys_type keys;
  int                      errors = 0, checks = 0, wr_cnt = 0;

  always #12.5 clk = ~clk;
  always @(posedge clk) if (awr === 1'h1) wr_cnt++;

  gimc_sensor_model SENS (.i_clk(clk), .i_r_on(r_on), .i_l_on(l_on),
    .o_right(rfnd), .o_left(lfnd));
  gimc_top #(.NUM_IN(5), .POS_W(16)) DUT (.i_clk(clk), .i_rst(rst),
    .i_din(din), .i_code(code), .i_guider_type(gtype), .i_operate(op),
    .i_auto_addr(amode), .i_card_group(grp), .i_right_param(rpar),
    .i_left_param(lpar), .i_right_found(rfnd), .i_left_found(lfnd),
    .i_web_dev(dev), .i_act_pos(act), .i_set_pos(setp),
    .i_master_pos(mpos), .o_block_pos(bpos), .o_block_neg(bneg),
    .o_osc_on(osc), .o_offset_sel(offs), .o_speed_sel(spd), .o_keys(keys),
    .o_target(tgt), .o_is_speed(isspd), .o_three_lvl(three),
    .o_hybrid(hyb), .o_addr_wr(awr), .o_right_addr(raddr),
    .o_left_addr(laddr));

  task automatic finish_test;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // addressing happens on the way out of reset, and again on a swap in parameter mode
  task automatic reset_with(input logic [1:0] m);
    @(posedge clk);
    amode <= m;
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    wr_cnt = 0;
    rst <= 1'h0;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic cfg(input logic [29:0] c);
    @(posedge clk);
    code <= c;
  endtask

  // one edge to sample, then look once the registered outputs settled
  task automatic setin(input logic [4:0] d);
    @(posedge clk);
    din <= d;
    @(posedge clk);
    #1;
  endtask

  task automatic t_addr;
    reset_with(gimc_pkg::AA_REPORT);
    `CHK("rep_r", {1'h1, 8'h5a}, raddr)
    `CHK("rep_l", {1'h1, 8'h6b}, laddr)
    `CHK("rep_wr", 0, wr_cnt)
    reset_with(gimc_pkg::AA_FIXED);
    `CHK("fix_r", {1'h1, grp, gimc_pkg::DEV_RIGHT}, raddr)
    `CHK("fix_l", {1'h1, grp, gimc_pkg::DEV_LEFT}, laddr)
    @(posedge clk) r_on <= 1'h0;
    repeat (4) @(posedge clk);
    r_on <= 1'h1;
    repeat (8) @(posedge clk);
    `CHK("fix_wr", 1, wr_cnt)
    reset_with(gimc_pkg::AA_PARAM);
    `CHK("par_r", {1'h1, rpar}, raddr)
    `CHK("par_l", {1'h1, lpar}, laddr)
    `CHK("par_wr", 1, wr_cnt)
    @(posedge clk) l_on <= 1'h0;
    repeat (4) @(posedge clk);
    l_on <= 1'h1;
    repeat (8) @(posedge clk);
    `CHK("swap_wr", 2, wr_cnt)
    `CHK("swap_l", {1'h1, lpar}, laddr)
  endtask

  task automatic t_locks;
    cfg({18'h0, 6'h3b, 6'h3a});
    setin(5'h03);
    `CHK("brk_idle", 2'h0, {bpos, bneg})
    setin(5'h02);
    `CHK("brk_neg", 2'h1, {bpos, bneg})
    setin(5'h01);
    `CHK("brk_pos", 2'h2, {bpos, bneg})
    cfg({18'h0, 6'h05, 6'h06});
    setin(5'h01);
    `CHK("make_neg", 2'h1, {bpos, bneg})
    cfg({18'h0, 6'h3c, 6'h3d});
    @(posedge clk) gtype <= gimc_pkg::GT_THREE;
    setp <= 16'h0010;
    setin(5'h00);
    `CHK("ser_lo", 2'h2, {bpos, bneg})
    `CHK("three_gate", 1'h0, three[1])
    setin(5'h01);
    `CHK("ser_hi", 2'h1, {bpos, bneg})
    `CHK("three_drv", 2'h2, three)
    setin(5'h03);
    `CHK("ser_ok", 2'h0, {bpos, bneg})
  endtask

  task automatic t_dedic;
    cfg({24'h0, 6'h09});
    setin(5'h1f);
    `CHK("off_in0", 1'h0, offs)
    cfg({6'h09, 24'h0});
    setin(5'h1f);
    `CHK("off_in4", 1'h1, offs)
    cfg({24'h0, 6'h0a});
    setin(5'h1f);
    `CHK("spd_in0", 1'h0, spd)
    cfg({6'h0a, 24'h0});
    setin(5'h1f);
    `CHK("spd_in4", 1'h1, spd)
  endtask

  task automatic t_keys_osc;
    cfg({6'h0f, 6'h0e, 6'h0d, 6'h0c, 6'h0b});
    setin(5'h1f);
    `CHK("keys_all", 5'h1f, keys)
    setin(5'h02);
    `CHK("key_right", 5'h08, keys)
    cfg({18'h0, 6'h38, 6'h08});
    setin(5'h01);
    `CHK("osc_set", 1'h1, osc)
    setin(5'h00);
    `CHK("osc_hold", 1'h1, osc)
    setin(5'h02);
    `CHK("osc_clr", 1'h0, osc)
    cfg({5{6'h20}});
    setin(5'h1f);
    `CHK("unk_out", 10'h0, {bpos, bneg, keys, offs, spd, osc})
  endtask

  task automatic t_guide;
    @(posedge clk);
    gtype <= gimc_pkg::GT_INTEG;
    setp <= 16'h0064;
    act <= 16'h0028;
    dev <= 16'h0007;
    op <= 1'h1;
    cfg({12'h0, 6'h10, 12'h0});
    setin(5'h04);
    `CHK("lat_hold", 16'h0064, tgt)
    `CHK("int_pos", 1'h0, isspd)
    `CHK("hybrid", 1'h1, hyb)
    @(posedge clk) dev <= 16'h0009; // a later deviation while high wins
    setin(5'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK("lat_add", 16'h006d, tgt)
    @(posedge clk) gtype <= gimc_pkg::GT_PROP;
    setin(5'h00);
    `CHK("prop_spd", 1'h1, isspd)
    `CHK("prop_err", 16'h003c, tgt)
    @(posedge clk) gtype <= gimc_pkg::GT_SLAVE;
    mpos <= 16'hfed4;
    setin(5'h00);
    `CHK("slave", 16'hfed4, tgt)
  endtask

  initial begin
    t_addr();
    t_locks();
    t_dedic();
    t_keys_osc();
    t_guide();
    finish_test();
  end

  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule
